// ---- gst_map.vh ----
`ifndef GST_MAP_VH
`define GST_MAP_VH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define GST_TIMER_CONTROL 12'h000
`define GST_GATE_CONTROL 12'h004
`define GST_COUNT_LOW 12'h008
`define GST_COUNT_HIGH 12'h00c
`define GST_MATCH_LOW 12'h010
`define GST_MATCH_HIGH 12'h014
`define GST_CCU_CONTROL 12'h018
`define GST_FLAGS 12'h01c
// ----------------------------------------------------------------
// Timer control fields
// ----------------------------------------------------------------
`define GST_TC_ON 0
`define GST_TC_SYNC_DIS 2
`define GST_TC_PS_LO 4
`define GST_TC_CS_LO 6
`define GST_TC_WMASK 8'hf5
// ----------------------------------------------------------------
// Gate control fields
// ----------------------------------------------------------------
`define GST_GC_SS_LO 0
`define GST_GC_VAL 2
`define GST_GC_ARMED 3
`define GST_GC_SPM 4
`define GST_GC_TM 5
`define GST_GC_POL 6
`define GST_GC_GE 7
// ----------------------------------------------------------------
// Clock sources, gate sources, unit modes, flags
// ----------------------------------------------------------------
`define GST_CS_INSTR 2'b00
`define GST_CS_SYS 2'b01
`define GST_CS_EXT 2'b10
`define GST_GS_PIN 2'b00
`define GST_GS_T0 2'b01
`define GST_GS_T2 2'b10
`define GST_GS_WDT 2'b11
`define GST_CM_OFF 2'b00
`define GST_CM_CAPTURE 2'b01
`define GST_CM_COMPARE 2'b10
`define GST_CM_SPECIAL 2'b11
`define GST_FL_OVF 0
`define GST_FL_GATE 1
`define GST_FL_CCU 2
`define GST_RESET_BYTE 8'h00
`define GST_INSTR_DIV 2'd3
`endif

// ---- gst_timer.v ----
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "gst_map.vh"
module gst_timer
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire external_clock_pin,
  input wire gate_pin,
  input wire timer0_overflow,
  input wire period_timer_match,
  input wire watchdog_scaler_overflow,
  input wire capture_event,
  output reg watchdog_osc_enable,
  output reg compare_event,
  output reg overflow_flag,
  output reg gate_event_flag
);

  // --------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------
  reg [7:0] timer_control_q;
  reg [7:0] gate_control_q;
  reg [15:0] count_q;
  reg [15:0] match_q;
  reg [1:0] ccu_mode_q;
  reg ccu_flag_q;
  reg wr_pend_q;
  reg [11:0] wr_addr_q;
  reg [1:0] instr_div_q;
  reg [2:0] pre_q;
  reg ext_s1_q;
  reg ext_s2_q;
  reg ext_prev_q;
  reg ext_raw_prev_q;
  reg toggle_q;
  reg gate_val_q;
  reg spm_open_q;
  reg src_prev_q;

  wire timer_on = timer_control_q[`GST_TC_ON];
  wire sync_dis = timer_control_q[`GST_TC_SYNC_DIS];
  wire [1:0] prescale = timer_control_q[`GST_TC_PS_LO+1:`GST_TC_PS_LO];
  wire [1:0] clk_src = timer_control_q[`GST_TC_CS_LO+1:`GST_TC_CS_LO];
  wire [1:0] gate_src = gate_control_q[`GST_GC_SS_LO+1:`GST_GC_SS_LO];
  wire gate_en = gate_control_q[`GST_GC_GE];
  wire gate_pol = gate_control_q[`GST_GC_POL];
  wire gate_tm = gate_control_q[`GST_GC_TM];
  wire gate_spm = gate_control_q[`GST_GC_SPM];
  wire spm_armed = gate_control_q[`GST_GC_ARMED];

  // Byte write qualified by the pending data phase
  function wr_hit;
    input pend;
    input [11:0] a;
    input [11:0] target;
    begin
      wr_hit = pend && (a == target);
    end
  endfunction

  wire w_tc = wr_hit(wr_pend_q, wr_addr_q, `GST_TIMER_CONTROL);
  wire w_gc = wr_hit(wr_pend_q, wr_addr_q, `GST_GATE_CONTROL);
  wire w_cl = wr_hit(wr_pend_q, wr_addr_q, `GST_COUNT_LOW);
  wire w_ch = wr_hit(wr_pend_q, wr_addr_q, `GST_COUNT_HIGH);
  wire w_ml = wr_hit(wr_pend_q, wr_addr_q, `GST_MATCH_LOW);
  wire w_mh = wr_hit(wr_pend_q, wr_addr_q, `GST_MATCH_HIGH);
  wire w_cm = wr_hit(wr_pend_q, wr_addr_q, `GST_CCU_CONTROL);
  wire w_fl = wr_hit(wr_pend_q, wr_addr_q, `GST_FLAGS);

  // --------------------------------------------------------------
  // Clock source and prescaler
  // --------------------------------------------------------------
  // Unsynchronised mode still samples the raw pin once; true
  // asynchronous counting cannot exist in a single clock design
  wire ext_rise_sync = ext_s2_q & ~ext_prev_q;
  wire ext_rise_raw = external_clock_pin & ~ext_raw_prev_q;
  reg src_tick;
  always @*
  begin
    case (clk_src)
      `GST_CS_INSTR: src_tick = (instr_div_q == `GST_INSTR_DIV);
      `GST_CS_SYS: src_tick = 1'b1;
      `GST_CS_EXT: src_tick = sync_dis ? ext_rise_raw : ext_rise_sync;
      default: src_tick = 1'b0;
    endcase
  end

  // Prescale terminal count: 0, 1, 3 or 7
  // Prescaler keeps stepping while the gate is shut; only the count waits
  wire [2:0] pre_max = (3'b001 << prescale) - 3'b001;
  wire pre_tick = src_tick && (pre_q == pre_max);

  // --------------------------------------------------------------
  // Gate path
  // --------------------------------------------------------------
  reg gate_src_lvl;
  always @*
  begin
    case (gate_src)
      `GST_GS_PIN: gate_src_lvl = gate_pin;
      `GST_GS_T0: gate_src_lvl = timer0_overflow;
      `GST_GS_T2: gate_src_lvl = period_timer_match;
      `GST_GS_WDT: gate_src_lvl = watchdog_scaler_overflow;
      default: gate_src_lvl = 1'b0;
    endcase
  end

  // Polarity applied first so the toggle flop steps on active edges
  // Toggle and single pulse may be combined to time whole gate cycles
  wire gate_act = gate_pol ? gate_src_lvl : ~gate_src_lvl;
  wire act_rise = gate_act & ~src_prev_q;
  wire gate_lvl = gate_tm ? toggle_q : gate_act;
  wire gate_rise = gate_lvl & ~gate_val_q;
  wire gate_fall = ~gate_lvl & gate_val_q;
  wire gate_ok = gate_spm ? (spm_open_q & gate_lvl) : gate_lvl;
  // Gate enable is a don't-care for the count while the timer is off
  wire count_en = timer_on && (!gate_en || gate_ok);

  // --------------------------------------------------------------
  // Capture/compare unit
  // --------------------------------------------------------------
  wire match_eq = (count_q == match_q);
  wire cmp_hit = (ccu_mode_q == `GST_CM_COMPARE) && match_eq;
  // Trigger is not gated by timer_on: a stopped count sitting on the
  // period value is still cleared, so software sees a clean start
  wire special = (ccu_mode_q == `GST_CM_SPECIAL) && match_eq;
  wire capture = (ccu_mode_q == `GST_CM_CAPTURE) && capture_event;
  wire inc = count_en && pre_tick;
  // A byte write in the wrap cycle replaces the count, so no rollover
  // took place and the overflow flag stays as it was
  wire w_cnt = w_cl || w_ch;
  wire wrap = inc && (count_q == 16'hffff) && !special && !w_cnt;

  // --------------------------------------------------------------
  // Clock divider, synchroniser and gate state
  // --------------------------------------------------------------
  // First sync stage feeds only the second stage
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      instr_div_q <= 2'd0;
      pre_q <= 3'd0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_prev_q <= 1'b0;
      ext_raw_prev_q <= 1'b0;
      toggle_q <= 1'b0;
      gate_val_q <= 1'b0;
      src_prev_q <= 1'b0;
      spm_open_q <= 1'b0;
    end
    else
    begin
      instr_div_q <= instr_div_q + 2'd1;
      ext_s1_q <= external_clock_pin;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      ext_raw_prev_q <= external_clock_pin;
      src_prev_q <= gate_act;
      gate_val_q <= gate_lvl;
      if (!timer_on)
        pre_q <= 3'd0;
      else if (pre_tick)
        pre_q <= 3'd0;
      else if (src_tick)
        pre_q <= pre_q + 3'd1;
      if (!timer_on || !gate_tm)
        toggle_q <= 1'b0;
      else if (act_rise)
        toggle_q <= ~toggle_q;
      // Window opens on the active edge while armed, shuts at trailing
      if (!gate_spm)
        spm_open_q <= 1'b0;
      else if (spm_armed && gate_rise)
        spm_open_q <= 1'b1;
      else if (gate_fall)
        spm_open_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Control, count and flag registers
  // --------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timer_control_q <= `GST_RESET_BYTE;
      gate_control_q <= `GST_RESET_BYTE;
      count_q <= 16'h0000;
      match_q <= 16'h0000;
      ccu_mode_q <= `GST_CM_OFF;
      ccu_flag_q <= 1'b0;
      overflow_flag <= 1'b0;
      gate_event_flag <= 1'b0;
      compare_event <= 1'b0;
      watchdog_osc_enable <= 1'b0;
    end
    else
    begin
      if (w_tc)
        timer_control_q <= hwdata[7:0] & `GST_TC_WMASK;
      if (w_gc)
      begin
        gate_control_q[7:4] <= hwdata[7:4];
        gate_control_q[1:0] <= hwdata[1:0];
      end
      gate_control_q[`GST_GC_VAL] <= gate_lvl;
      // Hardware clear of the armed bit wins over a software set
      if ((w_gc && !hwdata[`GST_GC_SPM]) || (!w_gc && !gate_spm))
        gate_control_q[`GST_GC_ARMED] <= 1'b0;
      else if (spm_open_q && gate_fall)
        gate_control_q[`GST_GC_ARMED] <= 1'b0;
      else if (w_gc)
        gate_control_q[`GST_GC_ARMED] <= hwdata[`GST_GC_ARMED];
      // Count: byte write first, then trigger clear, then increment
      if (w_cl || w_ch)
      begin
        if (w_cl)
          count_q[7:0] <= hwdata[7:0];
        if (w_ch)
          count_q[15:8] <= hwdata[7:0];
      end
      else if (special)
        count_q <= 16'h0000;
      else if (inc)
        count_q <= count_q + 16'h0001;
      // Capture beats a software match write in the same cycle
      if (capture)
        match_q <= count_q;
      else
      begin
        if (w_ml)
          match_q[7:0] <= hwdata[7:0];
        if (w_mh)
          match_q[15:8] <= hwdata[7:0];
      end
      if (w_cm)
        ccu_mode_q <= hwdata[1:0];
      compare_event <= cmp_hit || special;
      // Sticky flags: set beats write-one-to-clear
      if (wrap)
        overflow_flag <= 1'b1;
      else if (w_fl && hwdata[`GST_FL_OVF])
        overflow_flag <= 1'b0;
      if (gate_fall)
        gate_event_flag <= 1'b1;
      else if (w_fl && hwdata[`GST_FL_GATE])
        gate_event_flag <= 1'b0;
      if (cmp_hit || special || capture)
        ccu_flag_q <= 1'b1;
      else if (w_fl && hwdata[`GST_FL_CCU])
        ccu_flag_q <= 1'b0;
      // Oscillator request ignores timer_on so the gate source can run
      watchdog_osc_enable <= gate_en && (gate_src == `GST_GS_WDT);
    end
  end

  // --------------------------------------------------------------
  // AHB-Lite slave: zero wait, always OKAY
  // --------------------------------------------------------------
  // Unmapped offsets read zero; writes to them are dropped
  reg [31:0] rd_d;
  always @*
  begin
    rd_d = 32'h0000_0000;
    case (haddr)
      `GST_TIMER_CONTROL: rd_d[7:0] = timer_control_q;
      `GST_GATE_CONTROL: rd_d[7:0] = gate_control_q;
      `GST_COUNT_LOW: rd_d[7:0] = count_q[7:0];
      `GST_COUNT_HIGH: rd_d[7:0] = count_q[15:8];
      `GST_MATCH_LOW: rd_d[7:0] = match_q[7:0];
      `GST_MATCH_HIGH: rd_d[7:0] = match_q[15:8];
      `GST_CCU_CONTROL: rd_d[1:0] = ccu_mode_q;
      `GST_FLAGS: rd_d[2:0] = {ccu_flag_q, gate_event_flag, overflow_flag};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Read data registered at the address phase edge
  // Write address kept for one cycle to qualify the data phase
  // hsize is ignored: every register sits in the low byte of a word
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= hsel && hready && htrans[1] && hwrite;
      wr_addr_q <= haddr;
      if (hsel && hready && htrans[1] && !hwrite)
        hrdata <= rd_d;
    end
  end

endmodule // gst_timer

// ---- gst_far_model.sv ----
`timescale 1ns/1ns
// ------------------------------------------------------------
// External count clock source
// ------------------------------------------------------------
module gst_far_model
(
  input wire hclk,
  input wire hresetn,
  input wire go,
  input wire [7:0] edges,
  output reg ext_clk
);
  reg [7:0] left_q;
  reg [2:0] ph_q;
  // Bursts of edges eight clocks apart; parked low between bursts
  // so that no stray edge reaches the counter
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      left_q <= 8'h00;
      ph_q <= 3'h0;
      ext_clk <= 1'b0;
    end
    else if (go)
      left_q <= edges;
    else
    begin
      ph_q <= (left_q == 8'h00) ? 3'h0 : ph_q + 3'h1;
      ext_clk <= (left_q != 8'h00) && ph_q[2];
      if (ph_q == 3'h7)
        left_q <= left_q - 8'h01;
    end
endmodule // gst_far_model

// ---- gst_chk.sv ----
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bus and flag checker
// ------------------------------------------------------------
module gst_chk
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire watchdog_osc_enable,
  input wire overflow_flag,
  input wire gate_event_flag
);
  reg rd_q;
  reg wr_q;
  reg [11:0] a_q;
  reg [7:0] gc_q;
  wire take = hsel && hready && htrans[1];
  wire clr = wr_q && (a_q == 12'h01c);
  wire wd_want = gc_q[7] && (gc_q[1:0] == 2'h3);
  // Data phase tracking; gate byte shadow, since it is not a port
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      a_q <= 12'h000;
      gc_q <= 8'h00;
    end
    else
    begin
      if (wr_q && (a_q == 12'h004))
        gc_q <= hwdata[7:0];
      rd_q <= take && !hwrite;
      wr_q <= take && hwrite;
      a_q <= haddr;
    end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_HOLD: assert property ($changed(hrdata) |-> $past(take && !hwrite))
    else $error("read data moved without a read");
  AST_UPPER: assert property (rd_q |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_TC_RSVD: assert property (rd_q && a_q == 12'h0 |-> !hrdata[3] && !hrdata[1])
    else $error("unused control bits read one");
  AST_UNMAPPED: assert property (rd_q && a_q > 12'h01c |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_OVF_CLR: assert property ($fell(overflow_flag) |-> $past(clr && hwdata[0]))
    else $error("overflow flag fell without clear");
  AST_GATE_CLR: assert property ($fell(gate_event_flag) |-> $past(clr && hwdata[1]))
    else $error("gate flag fell without clear");
  AST_WDT: assert property (watchdog_osc_enable == $past(wd_want))
    else $error("watchdog enable wrong");
  COV_OVF: cover property ($rose(overflow_flag));
  COV_GATE: cover property ($rose(gate_event_flag));
  COV_WDT: cover property ($rose(watchdog_osc_enable));
endmodule // gst_chk
bind gst_timer gst_chk gst_chk_inst
(
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hrdata(hrdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .watchdog_osc_enable(watchdog_osc_enable),
  .overflow_flag(overflow_flag),
  .gate_event_flag(gate_event_flag)
);

// ---- gst_timer_tb.sv ----
`timescale 1ns/1ns
`include "gst_map.vh"
// ------------------------------------------------------------
// Timer bench
// ------------------------------------------------------------
module gst_timer_tb;
  reg hclk, hresetn, hwrite, ext_go, cap;
  reg [11:0] haddr;
  reg [1:0] htrans;
  reg [31:0] hwdata, r;
  reg [3:0] gsrc;
  wire [31:0] hrdata;
  wire hready, hresp, ext_clk, wdt_en, cmp_ev, ovf_fl, gate_fl;
  integer bad_count, n_compared, i, j;
  gst_timer gst_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .external_clock_pin(ext_clk), .gate_pin(gsrc[0]),
    .timer0_overflow(gsrc[1]), .period_timer_match(gsrc[2]),
    .watchdog_scaler_overflow(gsrc[3]), .capture_event(cap),
    .watchdog_osc_enable(wdt_en), .compare_event(cmp_ev),
    .overflow_flag(ovf_fl), .gate_event_flag(gate_fl));
  gst_far_model gst_far_model_inst (.hclk(hclk), .hresetn(hresetn),
    .go(ext_go), .edges(8'h05), .ext_clk(ext_clk));
  // Helpers: wait, one bus cycle, checks
  task run(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  task xf(input w, input [11:0] a, input [7:0] d);
  begin
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  end
  endtask
  task rng(input [31:0] g, input [31:0] lo, input [31:0] hi);
  begin
    n_compared = n_compared + 1;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      bad_count = bad_count + 1;
      $display("mismatch at %0t: got %h want %h", $time, g, lo);
    end
  end
  endtask
  task rc(input [11:0] a, input [7:0] m, input [7:0] e);
  begin
    xf(1'b0, a, 8'h00);
    rng(r & m, e, e);
  end
  endtask
  task wcnt(input [15:0] v);
  begin
    xf(1'b1, `GST_COUNT_LOW, v[7:0]);
    xf(1'b1, `GST_COUNT_HIGH, v[15:8]);
  end
  endtask
  task final_report;
  begin
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  // Reset values, unused bits, count bytes, capture and compare
  task t_regs;
  begin
    rc(`GST_TIMER_CONTROL, 8'hff, 8'h00);
    rc(12'h020, 8'hff, 8'h00);
    xf(1'b1, `GST_TIMER_CONTROL, 8'hff);
    rc(`GST_TIMER_CONTROL, 8'hff, 8'hf5);
    xf(1'b1, `GST_TIMER_CONTROL, 8'h00);
    wcnt(16'h1234);
    rc(`GST_COUNT_HIGH, 8'hff, 8'h12);
    xf(1'b1, `GST_CCU_CONTROL, `GST_CM_CAPTURE);
    cap <= 1'b1;
    run(1);
    cap <= 1'b0;
    rc(`GST_MATCH_LOW, 8'hff, 8'h34);
    rc(`GST_MATCH_HIGH, 8'hff, 8'h12);
    xf(1'b1, `GST_CCU_CONTROL, `GST_CM_COMPARE);
    run(3);
    rng(cmp_ev, 32'h1, 32'h1);
    xf(1'b1, `GST_MATCH_LOW, 8'h35);
    run(3);
    rng(cmp_ev, 32'h0, 32'h0);
  end
  endtask
  // Internal rates, external clock, wrap, special trigger period
  task t_count;
  begin
    for (i = 0; i < 10; i = i + 1)
    begin
      wcnt(16'h0000);
      xf(1'b1, `GST_TIMER_CONTROL, i < 8 ? {1'b0, i[2], i[1:0], 4'h1}
        : {5'h10, i[0], 2'h1});
      ext_go <= i >= 8;
      run(1);
      ext_go <= 1'b0;
      run(61);
      xf(1'b1, `GST_TIMER_CONTROL, 8'h00);
      j = i >= 8 ? 5 : 64 / ((i[2] ? 1 : 4) << i[1:0]);
      xf(1'b0, `GST_COUNT_LOW, 8'h00);
      rng(r, j - (i < 8), j + (i < 8));
    end
    rng(ovf_fl, 32'h0, 32'h0);
    wcnt(16'hfff0);
    xf(1'b1, `GST_TIMER_CONTROL, 8'h41);
    run(30);
    xf(1'b1, `GST_TIMER_CONTROL, 8'h00);
    rng(ovf_fl, 32'h1, 32'h1);
    rc(`GST_COUNT_HIGH, 8'hff, 8'h00);
    xf(1'b1, `GST_FLAGS, 8'h01);
    wcnt(16'h0000);
    xf(1'b1, `GST_MATCH_LOW, 8'h10);
    xf(1'b1, `GST_MATCH_HIGH, 8'h00);
    xf(1'b1, `GST_CCU_CONTROL, `GST_CM_SPECIAL);
    xf(1'b1, `GST_TIMER_CONTROL, 8'h41);
    run(98);
    xf(1'b1, `GST_TIMER_CONTROL, 8'h00);
    rng(ovf_fl, 32'h0, 32'h0);
    rc(`GST_FLAGS, 8'h04, 8'h04);
    rc(`GST_COUNT_HIGH, 8'hff, 8'h00);
    xf(1'b0, `GST_COUNT_LOW, 8'h00);
    rng(r, 32'hf, 32'hf);
    // Trigger on the all-ones count must clear it without an overflow
    wcnt(16'hfff8);
    xf(1'b1, `GST_MATCH_LOW, 8'hff);
    xf(1'b1, `GST_MATCH_HIGH, 8'hff);
    xf(1'b1, `GST_TIMER_CONTROL, 8'h41);
    run(20);
    xf(1'b1, `GST_TIMER_CONTROL, 8'h00);
    rng(ovf_fl, 32'h0, 32'h0);
    rc(`GST_COUNT_HIGH, 8'hff, 8'h00);
    xf(1'b1, `GST_CCU_CONTROL, `GST_CM_OFF);
  end
  endtask
  // Gate sources with high polarity, then single pulse acquisition
  task t_gate;
  begin
    for (i = 0; i < 4; i = i + 1)
    begin
      wcnt(16'h0000);
      xf(1'b1, `GST_GATE_CONTROL, {6'h30, i[1:0]});
      xf(1'b1, `GST_TIMER_CONTROL, 8'h41);
      run(10);
      rc(`GST_COUNT_LOW, 8'hff, 8'h00);
      xf(1'b1, `GST_FLAGS, 8'h02);
      run(1);
      rng(gate_fl, 32'h0, 32'h0);
      gsrc <= 4'h1 << i;
      run(20);
      rc(`GST_GATE_CONTROL, 8'h04, 8'h04);
      rng(wdt_en, i == 3, i == 3);
      gsrc <= 4'h0;
      run(4);
      xf(1'b1, `GST_TIMER_CONTROL, 8'h00);
      xf(1'b0, `GST_COUNT_LOW, 8'h00);
      rng(r, 32'h10, 32'h20);
      rng(gate_fl, 32'h1, 32'h1);
      xf(1'b1, `GST_FLAGS, 8'h02);
    end
    wcnt(16'h0000);
    xf(1'b1, `GST_GATE_CONTROL, 8'hd8);
    rc(`GST_GATE_CONTROL, 8'h18, 8'h18);
    xf(1'b1, `GST_TIMER_CONTROL, 8'h41);
    for (i = 0; i < 2; i = i + 1)
    begin
      gsrc <= 4'h1;
      run(10);
      gsrc <= 4'h0;
      run(4);
    end
    xf(1'b1, `GST_TIMER_CONTROL, 8'h00);
    rc(`GST_GATE_CONTROL, 8'h08, 8'h00);
    xf(1'b0, `GST_COUNT_LOW, 8'h00);
    rng(r, 32'h8, 32'he);
    xf(1'b1, `GST_GATE_CONTROL, 8'hd8);
    xf(1'b1, `GST_GATE_CONTROL, 8'h88);
    rc(`GST_GATE_CONTROL, 8'h08, 8'h00);
    // Toggle mode: count from one active edge to the next
    wcnt(16'h0000);
    xf(1'b1, `GST_GATE_CONTROL, 8'he0);
    xf(1'b1, `GST_TIMER_CONTROL, 8'h41);
    for (i = 0; i < 2; i = i + 1)
    begin
      gsrc <= 4'h1;
      run(4);
      gsrc <= 4'h0;
      run(16);
    end
    xf(1'b1, `GST_TIMER_CONTROL, 8'h00);
    xf(1'b0, `GST_COUNT_LOW, 8'h00);
    rng(r, 32'h13, 32'h15);
  end
  endtask
  // Clock, watchdog on a hang, main sequence
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial
  begin
    #200000;
    bad_count = bad_count + 1;
    final_report;
  end
  initial
  begin
    {hresetn, hwrite, ext_go, cap, gsrc} = 8'h00;
    {haddr, htrans, hwdata} = 46'h0;
    bad_count = 0;
    n_compared = 0;
    run(8);
    hresetn <= 1'b1;
    run(1);
    t_regs;
    t_count;
    t_gate;
    final_report;
  end
endmodule // gst_timer_tb
